// file: psi_pkg.sv
// shared constants and types for the program-flow and index block
package psi_pkg;
  localparam int PC_W = 12;
  localparam int STACK_DEPTH = 4;
  localparam int IDX_W = 16;
  localparam int CNT_W = 9;
  localparam int DADDR_W = 8;
  localparam int ACC_W = 16;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] PC_ONE = 12'h001;
  localparam logic [8:0] CNT_ONE = 9'h001;
  localparam logic [8:0] CNT_ZERO = 9'h000;
  localparam logic [11:0] INT_VECTOR = 12'h002;

  // operations from the instruction decoder
  typedef enum logic [3:0] {
    PSI_OP_NONE = 4'h0,
    PSI_OP_PUSH = 4'h1,
    PSI_OP_POP = 4'h2,
    PSI_OP_CALL = 4'h3,
    PSI_OP_CALL_ACC = 4'h4,
    PSI_OP_RET = 4'h5,
    PSI_OP_TBL_START = 4'h6,
    PSI_OP_TBL_END = 4'h7,
    PSI_OP_BRANCH = 4'h8,
    PSI_OP_BRANCH_NZ = 4'h9,
    PSI_OP_SET_SEL = 4'ha,
    PSI_OP_MODIFY = 4'hb,
    PSI_OP_LOAD_IMM = 4'hc,
    PSI_OP_LOAD_MEM = 4'hd,
    PSI_OP_STORE_MEM = 4'he,
    PSI_OP_INDIRECT = 4'hf
  } psi_op_t;

  // index adjust after an indirect access
  typedef enum logic [1:0] {
    PSI_ADJ_NONE = 2'h0,
    PSI_ADJ_INC = 2'h1,
    PSI_ADJ_DEC = 2'h2
  } psi_adj_t;

  // interrupt enable state, gray along enable/disable
  typedef enum logic [0:0] {
    PSI_INT_OFF = 1'b0,
    PSI_INT_ON = 1'b1
  } psi_int_t;
endpackage

// file: psi_idx_if.sv
// carrier between the core and its index-register unit
`timescale 1ns/1ns
interface psi_idx_if;
  logic adj_en;
  psi_pkg::psi_adj_t adj;
  logic adj_sel;
  logic load_en;
  logic load_sel;
  logic [15:0] load_val;
  logic rd_sel;
  logic [15:0] rd_val;
  logic [15:0] cur_val;
  logic cur_sel;
  modport core (output adj_en, adj, adj_sel, load_en, load_sel, load_val, rd_sel,
                input rd_val, cur_val, cur_sel);
  modport unit (input adj_en, adj, adj_sel, load_en, load_sel, load_val, rd_sel,
                output rd_val, cur_val, cur_sel);
endinterface

// file: psi_index_regs.sv
// two index registers with 9-bit loop counters
`timescale 1ns/1ns
module psi_index_regs (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // select pointer from the core
  input wire logic sel_i,
  // register access
  psi_idx_if.unit bus
);
  logic [15:0] idx_reg [2];
  logic [15:0] idx_next [2];

  // low 9 bits count; upper bits are kept but never carry
  function automatic logic [15:0] psi_step(input logic [15:0] v, input psi_pkg::psi_adj_t a);
    logic [8:0] c;
    c = v[8:0];
    if (a == psi_pkg::PSI_ADJ_INC)
      c = v[8:0] + psi_pkg::CNT_ONE;
    else if (a == psi_pkg::PSI_ADJ_DEC)
      c = v[8:0] - psi_pkg::CNT_ONE;
    return {v[15:9], c};
  endfunction

  // next value per register; explicit load beats adjust
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      idx_next[i] = idx_reg[i];
      if (bus.adj_en && bus.adj_sel == i[0])
        idx_next[i] = psi_step(idx_reg[i], bus.adj);
      if (bus.load_en && bus.load_sel == i[0])
        idx_next[i] = bus.load_val;
    end
  end

  // contents need no reset; cleared anyway for clean simulation
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I)
    begin
      idx_reg[0] <= 16'h0000;
      idx_reg[1] <= 16'h0000;
    end
    else
    begin
      idx_reg[0] <= idx_next[0];
      idx_reg[1] <= idx_next[1];
    end
  end

  assign bus.rd_val = idx_reg[bus.rd_sel];
  assign bus.cur_val = idx_reg[sel_i];
  assign bus.cur_sel = sel_i;
endmodule

// file: psi_core.sv
// program counter, return stack and index control of the core
`timescale 1ns/1ns
module psi_core (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // decoder command, one instruction per strobe
  input wire logic OP_VALID_I,
  input wire psi_pkg::psi_op_t OP_I,
  input wire logic [11:0] OP_ADDR_I,
  input wire logic OP_SEL_I,
  input wire logic OP_NEW_SEL_EN_I,
  input wire logic OP_NEW_SEL_I,
  input wire psi_pkg::psi_adj_t OP_ADJ_I,
  input wire logic [15:0] OP_IMM_I,
  // accumulator and memory data
  input wire logic [15:0] ACC_I,
  input wire logic [15:0] MEM_DATA_I,
  // interrupt control
  input wire logic INT_REQ_I,
  input wire logic INT_ENABLE_I,
  input wire logic INT_DISABLE_I,
  // program flow outputs
  output logic [11:0] PC_O,
  output logic [11:0] STACK_HEAD_O,
  output logic [11:0] POP_DATA_O,
  output logic POP_VALID_O,
  output logic INT_TAKEN_O,
  output logic INT_ENABLED_O,
  // data path outputs
  output logic [7:0] DATA_ADDR_O,
  output logic [15:0] INDEX_STORE_O,
  output logic INDEX_SELECT_POINTER_O
);
  logic [11:0] pc_reg;
  logic [11:0] pc_next;
  logic [11:0] stack_reg [psi_pkg::STACK_DEPTH];
  logic [11:0] stack_next [psi_pkg::STACK_DEPTH];
  logic index_select_pointer_reg;
  logic index_select_pointer_next;
  psi_pkg::psi_int_t int_state_reg;
  psi_pkg::psi_int_t int_state_next;
  logic [11:0] pop_data_reg;
  logic pop_valid_reg;
  logic int_taken_reg;
  logic [15:0] store_reg;

  psi_idx_if idx ();

  psi_index_regs u_idx (
    .CLK_SYS_I(CLK_SYS_I),
    .NRST_I(NRST_I),
    .sel_i(index_select_pointer_reg),
    .bus(idx)
  );

  // decoded strobes
  wire take_int = INT_REQ_I && (int_state_reg == psi_pkg::PSI_INT_ON);
  wire op_go = OP_VALID_I && !take_int;
  wire do_call = op_go && (OP_I == psi_pkg::PSI_OP_CALL);
  wire do_call_acc = op_go && (OP_I == psi_pkg::PSI_OP_CALL_ACC);
  wire do_ret = op_go && (OP_I == psi_pkg::PSI_OP_RET);
  wire do_push = op_go && (OP_I == psi_pkg::PSI_OP_PUSH);
  wire do_pop = op_go && (OP_I == psi_pkg::PSI_OP_POP);
  wire do_tbl_start = op_go && (OP_I == psi_pkg::PSI_OP_TBL_START);
  wire do_tbl_end = op_go && (OP_I == psi_pkg::PSI_OP_TBL_END);
  wire do_bnz = op_go && (OP_I == psi_pkg::PSI_OP_BRANCH_NZ);
  wire do_indirect = op_go && (OP_I == psi_pkg::PSI_OP_INDIRECT);
  wire do_modify = op_go && (OP_I == psi_pkg::PSI_OP_MODIFY);
  wire [11:0] pc_inc = pc_reg + psi_pkg::PC_ONE;
  wire idx_nonzero = (idx.cur_val[8:0] != psi_pkg::CNT_ZERO);

  // stack entry written on any push-like event
  wire push_any = do_push || do_call || do_call_acc || do_tbl_start || take_int;
  wire pop_any = do_pop || do_ret || do_tbl_end;
  wire [11:0] push_val = take_int ? pc_reg :
                         (do_call || do_call_acc) ? pc_inc :
                         do_tbl_start ? pc_inc :
                         ACC_I[11:0];

  // stack shift; the bottom entry falls off when full, no flag raised
  always_comb
  begin
    for (int i = 0; i < psi_pkg::STACK_DEPTH; i++)
      stack_next[i] = stack_reg[i];
    if (push_any)
    begin
      for (int i = psi_pkg::STACK_DEPTH - 1; i > 0; i--)
        stack_next[i] = stack_reg[i - 1];
      stack_next[0] = push_val;
    end
    else if (pop_any)
    begin
      for (int i = 0; i < psi_pkg::STACK_DEPTH - 1; i++)
        stack_next[i] = stack_reg[i + 1];
    end
  end

  // program counter selection
  always_comb
  begin
    pc_next = pc_reg;
    if (take_int)
      pc_next = psi_pkg::INT_VECTOR;
    else if (op_go)
    begin
      case (OP_I)
        psi_pkg::PSI_OP_CALL: pc_next = OP_ADDR_I;
        psi_pkg::PSI_OP_CALL_ACC: pc_next = ACC_I[11:0];
        psi_pkg::PSI_OP_RET: pc_next = stack_reg[0];
        psi_pkg::PSI_OP_TBL_END: pc_next = stack_reg[0];
        psi_pkg::PSI_OP_TBL_START: pc_next = ACC_I[11:0];
        psi_pkg::PSI_OP_BRANCH: pc_next = OP_ADDR_I;
        psi_pkg::PSI_OP_BRANCH_NZ: pc_next = idx_nonzero ? OP_ADDR_I : pc_inc;
        default: pc_next = pc_inc;
      endcase
    end
  end

  // pointer update; the current access has already used the old value
  always_comb
  begin
    index_select_pointer_next = index_select_pointer_reg;
    if (op_go && OP_I == psi_pkg::PSI_OP_SET_SEL)
      index_select_pointer_next = OP_IMM_I[0];
    else if ((do_indirect || do_modify) && OP_NEW_SEL_EN_I)
      index_select_pointer_next = OP_NEW_SEL_I;
  end

  // interrupt enable; software enable after a trap re-arms it
  always_comb
  begin
    int_state_next = int_state_reg;
    if (take_int || INT_DISABLE_I)
      int_state_next = psi_pkg::PSI_INT_OFF;
    else if (INT_ENABLE_I)
      int_state_next = psi_pkg::PSI_INT_ON;
  end

  // index unit commands
  assign idx.adj_en = do_indirect || do_modify || do_bnz;
  assign idx.adj = do_bnz ? psi_pkg::PSI_ADJ_DEC : OP_ADJ_I;
  assign idx.adj_sel = index_select_pointer_reg;
  assign idx.load_en = op_go && (OP_I == psi_pkg::PSI_OP_LOAD_IMM ||
                                 OP_I == psi_pkg::PSI_OP_LOAD_MEM);
  assign idx.load_sel = OP_SEL_I;
  assign idx.load_val = (OP_I == psi_pkg::PSI_OP_LOAD_IMM) ? OP_IMM_I : MEM_DATA_I;
  assign idx.rd_sel = OP_SEL_I;

  // pc and stack; stack cleared only so shift checks never meet unknowns
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I)
      pc_reg <= psi_pkg::PC_RESET;
    else
      pc_reg <= pc_next;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I)
      stack_reg <= '{default: psi_pkg::PC_RESET};
    else
      stack_reg <= stack_next;
  end

  // control state and registered outputs
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!NRST_I)
    begin
      index_select_pointer_reg <= 1'b0;
      int_state_reg <= psi_pkg::PSI_INT_OFF;
      pop_data_reg <= 12'h000;
      pop_valid_reg <= 1'b0;
      int_taken_reg <= 1'b0;
      store_reg <= 16'h0000;
    end
    else
    begin
      index_select_pointer_reg <= index_select_pointer_next;
      int_state_reg <= int_state_next;
      pop_data_reg <= do_pop ? stack_reg[0] : pop_data_reg;
      pop_valid_reg <= do_pop;
      int_taken_reg <= take_int;
      store_reg <= idx.rd_val;
    end
  end

  assign PC_O = pc_reg;
  assign STACK_HEAD_O = stack_reg[0];
  assign POP_DATA_O = pop_data_reg;
  assign POP_VALID_O = pop_valid_reg;
  assign INT_TAKEN_O = int_taken_reg;
  assign INT_ENABLED_O = (int_state_reg == psi_pkg::PSI_INT_ON);
  assign DATA_ADDR_O = idx.cur_val[7:0];
  assign INDEX_STORE_O = store_reg;
  assign INDEX_SELECT_POINTER_O = idx.cur_sel;

  // checks
  property p_reset_pc;
    @(posedge CLK_SYS_I) !NRST_I |=> (pc_reg == psi_pkg::PC_RESET);
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("pc not cleared by reset");

  property p_call_saves;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      do_call |=> (stack_reg[0] == $past(pc_inc)) && (pc_reg == $past(OP_ADDR_I));
  endproperty
  a_call_saves: assert property (p_call_saves) else $error("call did not save pc");

  property p_ret_restores;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      do_ret |=> (pc_reg == $past(stack_reg[0])) && (stack_reg[0] == $past(stack_reg[1]));
  endproperty
  a_ret_restores: assert property (p_ret_restores) else $error("return pc mismatch");

  property p_push_shift;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      do_push |=> (stack_reg[0] == $past(ACC_I[11:0])) && (stack_reg[3] == $past(stack_reg[2]));
  endproperty
  a_push_shift: assert property (p_push_shift) else $error("push shift wrong");

  property p_pop_data;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      do_pop |=> POP_VALID_O && (POP_DATA_O == $past(stack_reg[0]));
  endproperty
  a_pop_data: assert property (p_pop_data) else $error("pop data wrong");

  property p_int_disables;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      take_int |=> !INT_ENABLED_O && (stack_reg[0] == $past(pc_reg));
  endproperty
  a_int_disables: assert property (p_int_disables) else $error("entry wrong");

  property p_sel_delayed;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (do_indirect && OP_NEW_SEL_EN_I) |-> ##1 (index_select_pointer_reg == $past(OP_NEW_SEL_I));
  endproperty
  a_sel_delayed: assert property (p_sel_delayed) else $error("pointer not updated");

  property p_load_keeps_sel;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (op_go && OP_I == psi_pkg::PSI_OP_LOAD_IMM) |=> $stable(index_select_pointer_reg);
  endproperty
  a_load_keeps_sel: assert property (p_load_keeps_sel) else $error("load moved sel");

  property p_bnz_branch;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (do_bnz && idx_nonzero) |=> (pc_reg == $past(OP_ADDR_I));
  endproperty
  a_bnz_branch: assert property (p_bnz_branch) else $error("branch missed");

  property p_bnz_fall;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (do_bnz && !idx_nonzero) |=> (pc_reg == $past(pc_inc));
  endproperty
  a_bnz_fall: assert property (p_bnz_fall) else $error("zero count branched");

  property p_int_vector;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      take_int |=> (PC_O == psi_pkg::INT_VECTOR) && INT_TAKEN_O;
  endproperty
  a_int_vector: assert property (p_int_vector) else $error("bad vector");

  property p_int_stays_off;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (!INT_ENABLED_O && !INT_ENABLE_I) |=> !INT_ENABLED_O;
  endproperty
  a_int_stays_off: assert property (p_int_stays_off) else $error("self enabled");

  property p_tbl_level;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      do_tbl_start |=> (stack_reg[0] == $past(pc_inc)) && (stack_reg[1] == $past(stack_reg[0]));
  endproperty
  a_tbl_level: assert property (p_tbl_level) else $error("table level wrong");

  property p_acc_call;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      do_call_acc |=> (pc_reg == $past(ACC_I[11:0])) && (stack_reg[0] == $past(pc_inc));
  endproperty
  a_acc_call: assert property (p_acc_call) else $error("acc call wrong");

  property p_pop_shift;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      do_pop |=> (stack_reg[0] == $past(stack_reg[1]));
  endproperty
  a_pop_shift: assert property (p_pop_shift) else $error("pop shift wrong");

  property p_full_drop;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      push_any |=> (stack_reg[3] == $past(stack_reg[2])) && (stack_reg[1] == $past(stack_reg[0]));
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("bottom not dropped");

  property p_set_sel;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      (op_go && OP_I == psi_pkg::PSI_OP_SET_SEL) |=>
        (index_select_pointer_reg == $past(OP_IMM_I[0]));
  endproperty
  a_set_sel: assert property (p_set_sel) else $error("pointer not set");

  property p_modify_only;
    @(posedge CLK_SYS_I) disable iff (!NRST_I)
      do_modify |=> (pc_reg == $past(pc_inc)) && (stack_reg[0] == $past(stack_reg[0]));
  endproperty
  a_modify_only: assert property (p_modify_only) else $error("modify did more");
endmodule

// file: psi_core_test.sv
// self-checking bench for the program-flow and index block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module psi_core_test;
  logic CLK_SYS_I = 1'b0;
  logic NRST_I = 1'b0;
  logic OP_VALID_I = 1'b0;
  psi_pkg::psi_op_t OP_I = psi_pkg::PSI_OP_NONE;
  logic [11:0] OP_ADDR_I = 12'h000;
  logic OP_SEL_I = 1'b0;
  logic OP_NEW_SEL_EN_I = 1'b0;
  logic OP_NEW_SEL_I = 1'b0;
  psi_pkg::psi_adj_t OP_ADJ_I = psi_pkg::PSI_ADJ_NONE;
  logic [15:0] OP_IMM_I = 16'h0000;
  logic [15:0] ACC_I = 16'h0000;
  logic [15:0] MEM_DATA_I = 16'h0000;
  logic INT_REQ_I = 1'b0;
  logic INT_ENABLE_I = 1'b0;
  logic INT_DISABLE_I = 1'b0;
  logic [11:0] PC_O, STACK_HEAD_O, POP_DATA_O;
  logic POP_VALID_O, INT_TAKEN_O, INT_ENABLED_O, INDEX_SELECT_POINTER_O;
  logic [7:0] DATA_ADDR_O;
  logic [15:0] INDEX_STORE_O;
  int miscompares = 0;
  int tests_run = 0;

  // 25 mhz core clock
  always #20 CLK_SYS_I = ~CLK_SYS_I;

  psi_core u_psi_core (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .OP_VALID_I(OP_VALID_I),
    .OP_I(OP_I), .OP_ADDR_I(OP_ADDR_I), .OP_SEL_I(OP_SEL_I), .OP_NEW_SEL_EN_I(OP_NEW_SEL_EN_I),
    .OP_NEW_SEL_I(OP_NEW_SEL_I), .OP_ADJ_I(OP_ADJ_I), .OP_IMM_I(OP_IMM_I), .ACC_I(ACC_I),
    .MEM_DATA_I(MEM_DATA_I), .INT_REQ_I(INT_REQ_I), .INT_ENABLE_I(INT_ENABLE_I),
    .INT_DISABLE_I(INT_DISABLE_I), .PC_O(PC_O), .STACK_HEAD_O(STACK_HEAD_O),
    .POP_DATA_O(POP_DATA_O), .POP_VALID_O(POP_VALID_O), .INT_TAKEN_O(INT_TAKEN_O),
    .INT_ENABLED_O(INT_ENABLED_O), .DATA_ADDR_O(DATA_ADDR_O), .INDEX_STORE_O(INDEX_STORE_O),
    .INDEX_SELECT_POINTER_O(INDEX_SELECT_POINTER_O));

  // valid stays up so ops can run back to back; idle drops it
  task automatic op(input psi_pkg::psi_op_t o, input logic [11:0] a, input logic [15:0] imm);
    OP_VALID_I = 1'b1;
    OP_I = o;
    OP_ADDR_I = a;
    OP_IMM_I = imm;
    @(posedge CLK_SYS_I);
    #1;
  endtask

  task automatic idle(input string nm);
    OP_VALID_I = 1'b0;
    OP_NEW_SEL_EN_I = 1'b0;
    OP_ADJ_I = psi_pkg::PSI_ADJ_NONE;
    @(posedge CLK_SYS_I);
    #1;
    $display("test %s done", nm);
  endtask

  task automatic t_reset;
    `CHK("pc", psi_pkg::PC_RESET, PC_O)
    `CHK("int_en", 1'b0, INT_ENABLED_O)
    `CHK("pointer", 1'b0, INDEX_SELECT_POINTER_O)
    idle("reset");
  endtask

  task automatic t_call_push_pop;
    op(psi_pkg::PSI_OP_BRANCH, 12'h100, 16'h0000);
    op(psi_pkg::PSI_OP_CALL, 12'h200, 16'h0000);
    `CHK("pc", 12'h200, PC_O)
    `CHK("head", 12'h101, STACK_HEAD_O)
    ACC_I = 16'ha5c3;
    op(psi_pkg::PSI_OP_PUSH, 12'h000, 16'h0000);
    `CHK("head", 12'h5c3, STACK_HEAD_O)
    op(psi_pkg::PSI_OP_POP, 12'h000, 16'h0000);
    `CHK("pop_valid", 1'b1, POP_VALID_O)
    `CHK("pop_data", 12'h5c3, POP_DATA_O)
    `CHK("head", 12'h101, STACK_HEAD_O)
    op(psi_pkg::PSI_OP_RET, 12'h000, 16'h0000);
    `CHK("pc", 12'h101, PC_O)
    `CHK("pop_valid", 1'b0, POP_VALID_O)
    idle("call_push_pop");
  endtask

  // five pushes into four levels: the oldest is lost without a trace
  task automatic t_overflow;
    for (int i = 1; i <= 5; i++)
    begin
      ACC_I = 16'hf000 | 16'(i);
      op(psi_pkg::PSI_OP_PUSH, 12'h000, 16'h0000);
    end
    `CHK("head", 12'h005, STACK_HEAD_O)
    for (int i = 5; i >= 2; i--)
    begin
      op(psi_pkg::PSI_OP_POP, 12'h000, 16'h0000);
      `CHK("pop_data", 12'(i), POP_DATA_O)
    end
    idle("overflow");
  endtask

  task automatic t_acc_call_table;
    op(psi_pkg::PSI_OP_BRANCH, 12'h020, 16'h0000);
    ACC_I = 16'h8345;
    op(psi_pkg::PSI_OP_CALL_ACC, 12'h000, 16'h0000);
    `CHK("pc", 12'h345, PC_O)
    `CHK("head", 12'h021, STACK_HEAD_O)
    ACC_I = 16'h07ff;
    op(psi_pkg::PSI_OP_TBL_START, 12'h000, 16'h0000);
    `CHK("pc", 12'h7ff, PC_O)
    `CHK("head", 12'h346, STACK_HEAD_O)
    op(psi_pkg::PSI_OP_TBL_END, 12'h000, 16'h0000);
    `CHK("pc", 12'h346, PC_O)
    op(psi_pkg::PSI_OP_RET, 12'h000, 16'h0000);
    `CHK("pc", 12'h021, PC_O)
    idle("acc_call_table");
  endtask

  task automatic t_interrupt;
    INT_ENABLE_I = 1'b1;
    op(psi_pkg::PSI_OP_BRANCH, 12'h040, 16'h0000);
    INT_ENABLE_I = 1'b0;
    `CHK("int_en", 1'b1, INT_ENABLED_O)
    INT_REQ_I = 1'b1;
    op(psi_pkg::PSI_OP_BRANCH, 12'h123, 16'h0000);
    `CHK("taken", 1'b1, INT_TAKEN_O)
    `CHK("pc", psi_pkg::INT_VECTOR, PC_O)
    `CHK("head", 12'h040, STACK_HEAD_O)
    `CHK("int_en", 1'b0, INT_ENABLED_O)
    op(psi_pkg::PSI_OP_NONE, 12'h000, 16'h0000);
    INT_REQ_I = 1'b0;
    `CHK("taken", 1'b0, INT_TAKEN_O)
    op(psi_pkg::PSI_OP_RET, 12'h000, 16'h0000);
    `CHK("pc", 12'h040, PC_O)
    // software enable, then disable, then both at once: disable wins
    INT_ENABLE_I = 1'b1;
    op(psi_pkg::PSI_OP_NONE, 12'h000, 16'h0000);
    `CHK("int_en", 1'b1, INT_ENABLED_O)
    INT_ENABLE_I = 1'b0;
    INT_DISABLE_I = 1'b1;
    op(psi_pkg::PSI_OP_NONE, 12'h000, 16'h0000);
    `CHK("int_en", 1'b0, INT_ENABLED_O)
    INT_ENABLE_I = 1'b1;
    op(psi_pkg::PSI_OP_NONE, 12'h000, 16'h0000);
    `CHK("int_en", 1'b0, INT_ENABLED_O)
    INT_ENABLE_I = 1'b0;
    INT_DISABLE_I = 1'b0;
    idle("interrupt");
  endtask

  task automatic t_index;
    OP_SEL_I = 1'b0;
    op(psi_pkg::PSI_OP_LOAD_IMM, 12'h000, 16'h0105);
    OP_SEL_I = 1'b1;
    op(psi_pkg::PSI_OP_LOAD_IMM, 12'h000, 16'h0033);
    op(psi_pkg::PSI_OP_SET_SEL, 12'h000, 16'h0001);
    `CHK("pointer", 1'b1, INDEX_SELECT_POINTER_O)
    `CHK("daddr", 8'h33, DATA_ADDR_O)
    op(psi_pkg::PSI_OP_SET_SEL, 12'h000, 16'h0000);
    `CHK("daddr", 8'h05, DATA_ADDR_O)
    op(psi_pkg::PSI_OP_STORE_MEM, 12'h000, 16'h0000);
    `CHK("store", 16'h0033, INDEX_STORE_O)
    `CHK("pointer", 1'b0, INDEX_SELECT_POINTER_O)
    OP_NEW_SEL_EN_I = 1'b1;
    OP_NEW_SEL_I = 1'b1;
    OP_ADJ_I = psi_pkg::PSI_ADJ_INC;
    `CHK("daddr", 8'h05, DATA_ADDR_O)
    op(psi_pkg::PSI_OP_INDIRECT, 12'h000, 16'h0000);
    `CHK("daddr", 8'h33, DATA_ADDR_O)
    OP_NEW_SEL_EN_I = 1'b0;
    OP_ADJ_I = psi_pkg::PSI_ADJ_DEC;
    op(psi_pkg::PSI_OP_MODIFY, 12'h000, 16'h0000);
    `CHK("daddr", 8'h32, DATA_ADDR_O)
    OP_SEL_I = 1'b0;
    op(psi_pkg::PSI_OP_STORE_MEM, 12'h000, 16'h0000);
    `CHK("store", 16'h0106, INDEX_STORE_O)
    MEM_DATA_I = 16'h00c7;
    op(psi_pkg::PSI_OP_LOAD_MEM, 12'h000, 16'h0000);
    op(psi_pkg::PSI_OP_STORE_MEM, 12'h000, 16'h0000);
    `CHK("store", 16'h00c7, INDEX_STORE_O)
    idle("index");
  endtask

  // count of one branches once, then zero falls through and wraps
  task automatic t_loop;
    OP_SEL_I = 1'b1;
    op(psi_pkg::PSI_OP_LOAD_IMM, 12'h000, 16'h0001);
    op(psi_pkg::PSI_OP_BRANCH, 12'h050, 16'h0000);
    op(psi_pkg::PSI_OP_BRANCH_NZ, 12'h0aa, 16'h0000);
    `CHK("pc", 12'h0aa, PC_O)
    `CHK("daddr", 8'h00, DATA_ADDR_O)
    op(psi_pkg::PSI_OP_BRANCH_NZ, 12'h0bb, 16'h0000);
    `CHK("pc", 12'h0ab, PC_O)
    `CHK("daddr", 8'hff, DATA_ADDR_O)
    op(psi_pkg::PSI_OP_STORE_MEM, 12'h000, 16'h0000);
    `CHK("count", psi_pkg::CNT_ZERO - psi_pkg::CNT_ONE, INDEX_STORE_O[8:0])
    idle("loop");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard well beyond the scripted length
  initial
  begin
    repeat (5000) @(posedge CLK_SYS_I);
    miscompares++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge CLK_SYS_I);
    #1;
    NRST_I = 1'b1;
    t_reset();
    t_call_push_pop();
    t_overflow();
    t_acc_call_table();
    t_interrupt();
    t_index();
    t_loop();
    conclude();
  end
endmodule
